//--- core/ioc_consts.svh
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define IOC_ADDR_W          12
`define IOC_OFS_CFG         12'h054
`define IOC_OFS_STATUS      12'h058
`define IOC_OFS_ENABLE      12'h05c
`define IOC_OFS_RESET_CONTROL 12'h1f8

// ****************************************
// Configuration and reset control register fields
// ****************************************
`define IOC_HOLDOFF_HI      31
`define IOC_HOLDOFF_LO      24
`define IOC_CLR_BIT         14
`define IOC_ACTIVE_BIT      13
`define IOC_MASTER_BIT      12
`define IOC_EN_BIT          8
`define IOC_POL_BIT         4
`define IOC_TYPE_BIT        0
`define IOC_SOFT_RST_BIT    0

// ****************************************
// Sources and reset values
// ****************************************
`define IOC_NSRC            8
`define IOC_HOLDOFF_RST     8'h00
`define IOC_SRC_RST         8'h00

// ****************************************
// Timing
// ****************************************
`define IOC_CLK_HZ          20000000
`define IOC_TICK_NS         10000
`define IOC_TICK_CYC        ((`IOC_TICK_NS * (`IOC_CLK_HZ / 1000000)) / 1000)
`define IOC_PRE_W           10

`endif

//--- core/ioc_pkg.sv
package ioc_pkg;
  // Hold-off sequencer states
  typedef enum logic [2:0] {
    IOC_IDLE   = 3'b001,
    IOC_ASSERT = 3'b010,
    IOC_HOLD   = 3'b100
  } ioc_state_t;
endpackage : ioc_pkg

//--- core/ioc_src_flag.sv
`timescale 1ns/10ps
`include "ioc_consts.svh"

module ioc_src_flag (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic soft_rst,
  // Event and acknowledge
  input  wire logic event_in,
  input  wire logic ack_in,
  // Flag
  output logic      flag_reg
);
  logic flag_next;

  // A new event wins over a same-cycle acknowledge
  assign flag_next = event_in | (flag_reg & ~ack_in);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (soft_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule : ioc_src_flag

//--- core/ioc_irq_output.sv
// Contract
// - Bits 31:24 hold hold-off length in 10 us steps, reset zero.
// - Zero hold-off disables interval, clears counter, pending interrupt goes out immediately.
// - A new non-zero hold-off length applies to all later interrupts.
// - Writing one to bit 14 restarts the interval; self-clearing, reads zero.
// - Bit 13 reads one while an interval withholds interrupts from the pin.
// - Bit 12 shows combined enabled-source line, independent of enable and hold-off.
// - Bit 8 gates the pin; zero keeps it inactive, status untouched.
// - Bit 4 selects polarity: zero active low, one active high; reset zero.
// - In open-drain mode polarity is ignored and interrupt always drives low.
// - Bit 0 picks driver: zero open-drain pull-low only, one push-pull.
// - Polarity and driver bits survive soft reset; other fields return to defaults.
// - Only enabled sources reach the combined line; flags track regardless of enable.
// - Writing one clears a latched flag; writing zero leaves it.
`timescale 1ns/10ps
`include "ioc_consts.svh"

module ioc_irq_output
  import ioc_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`IOC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Interrupt sources
  input  wire logic [`IOC_NSRC-1:0]   src_event,
  // Interrupt pin
  output logic                        irq_out,
  output logic                        irq_oe
);

  // ****************************************
  // Decode
  // ****************************************
  wire wr_cfg    = reg_wr && (reg_addr == `IOC_OFS_CFG);
  wire wr_status = reg_wr && (reg_addr == `IOC_OFS_STATUS);
  wire wr_enable = reg_wr && (reg_addr == `IOC_OFS_ENABLE);
  wire wr_rstctl = reg_wr && (reg_addr == `IOC_OFS_RESET_CONTROL);
  wire soft_rst  = wr_rstctl && reg_wdata[`IOC_SOFT_RST_BIT];

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]           holdoff_interval_reg;
  logic                 irq_en_reg;
  logic                 pin_polarity_select_reg;
  logic                 pin_push_pull_reg;
  logic [`IOC_NSRC-1:0] src_enable_reg;
  logic [`IOC_NSRC-1:0] source_status_reg;
  logic                 master_reg;
  ioc_state_t           state_reg;
  ioc_state_t           state_next;
  logic [7:0]           tick_cnt_reg;
  logic [7:0]           tick_cnt_next;
  logic [`IOC_PRE_W-1:0] pre_reg;
  logic [`IOC_PRE_W-1:0] pre_next;

  wire holdoff_counter_clear = wr_cfg && reg_wdata[`IOC_CLR_BIT];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdoff_interval_reg <= `IOC_HOLDOFF_RST;
      irq_en_reg           <= 1'b0;
      src_enable_reg       <= `IOC_SRC_RST;
    end else if (soft_rst) begin
      holdoff_interval_reg <= `IOC_HOLDOFF_RST;
      irq_en_reg           <= 1'b0;
      src_enable_reg       <= `IOC_SRC_RST;
    end else begin
      if (wr_cfg) begin
        holdoff_interval_reg <= reg_wdata[`IOC_HOLDOFF_HI:`IOC_HOLDOFF_LO];
        irq_en_reg           <= reg_wdata[`IOC_EN_BIT];
      end
      if (wr_enable) begin
        src_enable_reg <= reg_wdata[`IOC_NSRC-1:0];
      end
    end
  end

  // Polarity and driver type are retained over soft reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_polarity_select_reg <= 1'b0;
      pin_push_pull_reg       <= 1'b0;
    end else if (wr_cfg) begin
      pin_polarity_select_reg <= reg_wdata[`IOC_POL_BIT];
      pin_push_pull_reg       <= reg_wdata[`IOC_TYPE_BIT];
    end
  end

  // ****************************************
  // Source flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `IOC_NSRC; gi++) begin : g_src
      ioc_src_flag u_flag (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .event_in (src_event[gi]),
        .ack_in   (wr_status && reg_wdata[gi]),
        .flag_reg (source_status_reg[gi])
      );
    end
  endgenerate

  wire master_next = |(source_status_reg & src_enable_reg);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      master_reg <= 1'b0;
    end else begin
      master_reg <= master_next;
    end
  end

  // ****************************************
  // Prescaler: one tick per 10 us
  // ****************************************
  wire pre_wrap = (pre_reg == `IOC_PRE_W'(`IOC_TICK_CYC - 1));
  wire in_hold  = (state_reg == IOC_HOLD);

  // Restarted at each interval start so the first tick is a full step
  wire interval_start = (state_next == IOC_HOLD) && (!in_hold || holdoff_counter_clear);
  assign pre_next = (interval_start || pre_wrap) ? '0 : pre_reg + 1'b1;

  // ****************************************
  // Hold-off sequencer
  // ****************************************
  wire holdoff_off = (holdoff_interval_reg == `IOC_HOLDOFF_RST);
  wire done        = pre_wrap && (tick_cnt_reg + 8'h01 >= holdoff_interval_reg);
  wire want_pin    = master_reg && irq_en_reg;
  // A restart uses the length written beside it, so one write may set and start
  wire clear_start = holdoff_counter_clear &&
                     (reg_wdata[`IOC_HOLDOFF_HI:`IOC_HOLDOFF_LO] != `IOC_HOLDOFF_RST);

  always_comb begin
    state_next    = state_reg;
    tick_cnt_next = tick_cnt_reg;
    case (state_reg)
      IOC_IDLE: begin
        tick_cnt_next = 8'h00;
        if (clear_start) begin
          state_next = IOC_HOLD;
        end else if (want_pin) begin
          state_next = IOC_ASSERT;
        end
      end
      IOC_ASSERT: begin
        tick_cnt_next = 8'h00;
        if (!want_pin || clear_start) begin
          state_next = (holdoff_off && !clear_start) ? IOC_IDLE : IOC_HOLD;
        end
      end
      IOC_HOLD: begin
        if (holdoff_off) begin
          state_next    = IOC_IDLE;
          tick_cnt_next = 8'h00;
        end else if (holdoff_counter_clear) begin
          tick_cnt_next = 8'h00;
        end else if (done) begin
          state_next    = IOC_IDLE;
          tick_cnt_next = 8'h00;
        end else if (pre_wrap) begin
          tick_cnt_next = tick_cnt_reg + 8'h01;
        end
      end
      default: begin
        state_next    = IOC_IDLE;
        tick_cnt_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= IOC_IDLE;
      tick_cnt_reg <= 8'h00;
      pre_reg      <= '0;
    end else if (soft_rst) begin
      state_reg    <= IOC_IDLE;
      tick_cnt_reg <= 8'h00;
      pre_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      pre_reg      <= pre_next;
    end
  end

  // ****************************************
  // Pin driver
  // ****************************************
  wire pin_active = (state_next == IOC_ASSERT);
  wire level_next = pin_push_pull_reg ? (pin_active ~^ pin_polarity_select_reg)
                                      : 1'b0;
  wire oe_next    = pin_push_pull_reg | pin_active;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      irq_out <= level_next;
      irq_oe  <= oe_next;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  logic [31:0] cfg_view;
  logic [31:0] rdata_next;

  always_comb begin
    cfg_view = 32'h0000_0000;
    cfg_view[`IOC_HOLDOFF_HI:`IOC_HOLDOFF_LO] = holdoff_interval_reg;
    cfg_view[`IOC_ACTIVE_BIT] = in_hold;
    cfg_view[`IOC_MASTER_BIT] = master_reg;
    cfg_view[`IOC_EN_BIT]     = irq_en_reg;
    cfg_view[`IOC_POL_BIT]    = pin_polarity_select_reg;
    cfg_view[`IOC_TYPE_BIT]   = pin_push_pull_reg;
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `IOC_OFS_CFG:    rdata_next = cfg_view;
        `IOC_OFS_STATUS: rdata_next = {24'h00_0000, source_status_reg};
        `IOC_OFS_ENABLE: rdata_next = {24'h00_0000, src_enable_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule : ioc_irq_output

//--- testbench/ioc_irq_output_assertions.sv
`timescale 1ns/10ps
`include "ioc_consts.svh"

module ioc_irq_output_checker (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // Register port
  input wire logic [`IOC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // Sources and pin
  input wire logic [`IOC_NSRC-1:0]   src_event,
  input wire logic                   irq_out,
  input wire logic                   irq_oe
);
  // ****
  // Shadow of enable, polarity, type
  // ****
  logic [2:0] cfg_reg;
  logic [2:0] cfg_next;
  logic [2:0] p1_reg;
  logic [2:0] p2_reg;
  wire cfg_wr   = reg_wr && reg_addr == `IOC_OFS_CFG;
  wire srst_wr  = reg_wr && reg_addr == `IOC_OFS_RESET_CONTROL && reg_wdata[0];
  wire settled  = cfg_reg == p1_reg && p1_reg == p2_reg;
  wire idle_pin = cfg_reg[0] ? (irq_oe && irq_out == !cfg_reg[1]) : !irq_oe;
  // Soft reset drops the enable only
  assign cfg_next = cfg_wr ? {reg_wdata[8], reg_wdata[4], reg_wdata[0]} :
                    srst_wr ? {1'b0, cfg_reg[1:0]} : cfg_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= 3'h0;
      p1_reg  <= 3'h0;
      p2_reg  <= 3'h0;
    end else begin
      cfg_reg <= cfg_next;
      p1_reg  <= cfg_reg;
      p2_reg  <= p1_reg;
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_clr_wr;
    cfg_wr && reg_wdata[14] && reg_wdata[31:24] != 8'h00;
  endsequence
  a_clr_reads_zero: assert property (reg_rd && reg_addr == `IOC_OFS_CFG |=> !reg_rdata[14])
    else $error("restart bit read back as one");
  a_cfg_readback: assert property (reg_rd && reg_addr == `IOC_OFS_CFG
    |=> {reg_rdata[8], reg_rdata[4], reg_rdata[0]} == $past(cfg_reg))
    else $error("pin configuration bits read back wrong");
  a_od_pulls_low: assert property (!cfg_reg[0] && settled && irq_oe |-> !irq_out)
    else $error("open-drain pin driven high");
  a_pp_drives: assert property (cfg_reg[0] && settled |-> irq_oe)
    else $error("push-pull pin not driven");
  a_off_idle: assert property (!cfg_reg[2] && settled |-> idle_pin)
    else $error("disabled pin not inactive");
  a_clr_restart: assert property (s_clr_wr |=> ##2 idle_pin [*3])
    else $error("restart did not hold pin inactive");
  a_soft_idle: assert property (srst_wr |=> ##2 idle_pin)
    else $error("pin active after soft reset");
  a_hold_withheld: assert property ($past(reg_rd) && reg_rdata[13] && settled |-> idle_pin)
    else $error("pin active during hold-off");
endmodule : ioc_irq_output_checker

bind ioc_irq_output ioc_irq_output_checker i_ioc_irq_output_checker (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
  .irq_out(irq_out), .irq_oe(irq_oe));

//--- testbench/ioc_host_irq_model.sv
`timescale 1ns/10ps

module ioc_host_irq_model (
  // Pin from the device
  input  wire logic irq_out,
  input  wire logic irq_oe,
  // Host side view
  input  wire logic active_high,
  output wire logic pin,
  output wire logic irq_seen
);
  // Pull-up holds the line when nobody drives it
  assign pin      = irq_oe ? irq_out : 1'b1;
  assign irq_seen = active_high ? pin : !pin;
endmodule : ioc_host_irq_model

//--- testbench/ioc_irq_output_tb.sv
`timescale 1ns/10ps
`include "ioc_consts.svh"

module ioc_irq_output_tb;
  localparam logic [11:0] CFG = `IOC_OFS_CFG;
  localparam logic [11:0] ST  = `IOC_OFS_STATUS;
  localparam logic [11:0] EN  = `IOC_OFS_ENABLE;
  logic                   sys_clk   = 1'b0;
  logic                   rst       = 1'b1;
  logic                   reg_wr    = 1'b0;
  logic                   reg_rd    = 1'b0;
  logic                   act_hi    = 1'b0;
  logic [`IOC_ADDR_W-1:0] reg_addr  = '0;
  logic [31:0]            reg_wdata = 32'h0;
  logic [`IOC_NSRC-1:0]   src_event = '0;
  logic [31:0]            reg_rdata;
  logic                   irq_out;
  logic                   irq_oe;
  logic                   pin;
  logic                   irq_seen;
  int                     n_errors  = 0;
  int                     n_checks  = 0;

  always #25 sys_clk = ~sys_clk;

  ioc_irq_output i_ioc_irq_output (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_event(src_event), .irq_out(irq_out), .irq_oe(irq_oe));
  ioc_host_irq_model i_ioc_host_irq_model (.irq_out(irq_out), .irq_oe(irq_oe),
    .active_high(act_hi), .pin(pin), .irq_seen(irq_seen));

  // ****
  // Access tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk("rdata", reg_rdata & m, e);
  endtask : rd
  task automatic evt(input int i);
    @(posedge sys_clk);
    src_event <= 8'h01 << i;
    @(posedge sys_clk);
    src_event <= 8'h00;
  endtask : evt
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ****
  // Tests
  // ****
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CFG, 32'hffffffff, 32'h0);
    rd(12'h060, 32'hffffffff, 32'h0);
    chk("pin", irq_seen, 1'b0);
    wr(EN, 32'h1);
    wr(CFG, 32'h111);
    act_hi <= 1'b1;
    evt(0);
    cyc(2);
    chk("pin", irq_seen, 1'b1);
    wr(CFG, 32'h011);
    cyc(3);
    chk("pin", irq_seen, 1'b0);
    rd(CFG, 32'h1000, 32'h1000);
    wr(ST, 32'h0);
    evt(1);
    rd(ST, 32'hff, 32'h3);
    wr(ST, 32'h3);
    rd(ST, 32'hff, 32'h0);
    rd(CFG, 32'h1000, 32'h0);
    wr(CFG, 32'h01000111);
    evt(0);
    cyc(2);
    chk("pin", irq_seen, 1'b1);
    wr(ST, 32'h1);
    cyc(4);
    chk("pin", irq_seen, 1'b0);
    rd(CFG, 32'h2000, 32'h2000);
    evt(0);
    cyc(150);
    chk("pin", irq_seen, 1'b0);
    cyc(60);
    chk("pin", irq_seen, 1'b1);
    wr(CFG, 32'h01004111);
    cyc(3);
    chk("pin", irq_seen, 1'b0);
    rd(CFG, 32'h6000, 32'h2000);
    wr(CFG, 32'h111);
    cyc(3);
    chk("pin", irq_seen, 1'b1);
    rd(CFG, 32'h2000, 32'h0);
    wr(CFG, 32'h110);
    act_hi <= 1'b0;
    cyc(3);
    chk("pin", {irq_seen, irq_oe, pin}, 3'b110);
    wr(ST, 32'h1);
    cyc(3);
    chk("oe", irq_oe, 1'b0);
    wr(CFG, 32'h01000111);
    wr(`IOC_OFS_RESET_CONTROL, 32'h1);
    rd(CFG, 32'hffffffff, 32'h11);
    wr(EN, 32'h1);
    wr(CFG, 32'h101);
    evt(0);
    cyc(2);
    chk("pin", {irq_out, irq_oe, irq_seen}, 3'b011);
    wr(ST, 32'h1);
    cyc(3);
    chk("pin", {irq_out, irq_oe, irq_seen}, 3'b110);
    wr(CFG, 32'h01004101);
    evt(0);
    cyc(3);
    chk("pin", irq_seen, 1'b0);
    rd(CFG, 32'h3000, 32'h3000);
    cyc(200);
    chk("pin", irq_seen, 1'b1);
    conclude;
  end

  initial begin
    #200000;
    n_errors++;
    conclude;
  end
endmodule : ioc_irq_output_tb
